// File: rtl/encoder_divided_pulse_output.sv
// encoder divided pulse output: quadrature a/b, index c, wishbone registers
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "edpo_regs.svh"
// Function
// - a and b form a 90 degree quadrature pair
// - rotary: pulses per revolution from setting
// - linear: pulses follow output resolution setting
// - rotary: one index pulse per revolution
// - index pulse as wide as phase a
// - reverse motion keeps same phase form
// - option 0: index only moving forward (linear only; rotary raises the index in both directions)
// - option 1: index in both directions
// - both mode may give narrower index
// - both mode shifts detection one eighth pitch
// - forward-only uses encoder count direction
// - after first forward index, emit both ways
// - reverse crossings suppressed until forward index
// - direction dependent origin marks give two positions
// - output count divides encoder count by setting
// - output rate limited to about 1.6 mpps
module encoder_divided_pulse_output import edpo_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_enc_step,
    input wire logic i_enc_dir,
    input wire logic i_enc_origin,
    output logic o_phase_a_out,
    output logic o_phase_a_out_n,
    output logic o_phase_b_out,
    output logic o_phase_b_out_n,
    output logic o_index_out,
    output logic o_index_out_n
);
    edpo_state_t s;
    edpo_state_t next_s;
    logic div_up;
    logic div_down;
    logic qa;
    logic qb;
    logic q_edge;
    logic q_busy;
    logic bus_req;
    logic origin_ok;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] dat,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // encoder counts scaled to output edges
    pulse_divider u_divider (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_restart(s.restart),
        .i_step(i_enc_step),
        .i_dir(i_enc_dir),
        .i_num(s.act_num),
        .i_den(s.act_den),
        .o_up(div_up),
        .o_down(div_down)
    );

    // edges paced out as quadrature
    quad_edge_gen u_edges (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_restart(s.restart),
        .i_up(div_up),
        .i_down(div_down),
        .o_a(qa),
        .o_b(qb),
        .o_edge(q_edge),
        .o_busy(q_busy)
    );

    assign bus_req = i_wb_cyc && i_wb_stb && !s.ack;

    // which origin crossings may raise the index
    always_comb begin
        if (!s.act_linear) begin
            origin_ok = i_enc_origin;
        end else if (!s.act_both) begin
            origin_ok = i_enc_origin && i_enc_dir;
        end else begin
            origin_ok = i_enc_origin && (i_enc_dir || s.armed);
        end
    end

    always_comb begin
        next_s = s;
        next_s.restart = 1'b0;
        next_s.ack = bus_req;
        // register writes land on the acknowledging cycle
        if (bus_req && i_wb_we) begin
            case (i_wb_adr)
                `ADDR_INDEX_OPT: begin
                    next_s.idx_opt = 16'(merge_bytes({16'h0000, s.idx_opt}, i_wb_dat, i_wb_sel));
                end
                `ADDR_CONFIG: begin
                    if (i_wb_sel[0]) begin
                        next_s.linear = i_wb_dat[`CFG_LINEAR_BIT];
                        next_s.restart = i_wb_dat[`CFG_RESTART_BIT];
                    end
                end
                `ADDR_PPR: begin
                    next_s.ppr = merge_bytes(s.ppr, i_wb_dat, i_wb_sel);
                end
                `ADDR_LRES: begin
                    next_s.lres = merge_bytes(s.lres, i_wb_dat, i_wb_sel);
                end
                `ADDR_ENC_RES: begin
                    next_s.enc_res = merge_bytes(s.enc_res, i_wb_dat, i_wb_sel);
                end
                `ADDR_PITCH: begin
                    next_s.pitch = merge_bytes(s.pitch, i_wb_dat, i_wb_sel);
                end
                default: begin
                end
            endcase
        end
        next_s.rdata = 32'h00000000;
        if (bus_req && !i_wb_we) begin
            case (i_wb_adr)
                `ADDR_INDEX_OPT: next_s.rdata = {16'h0000, s.idx_opt};
                `ADDR_CONFIG: next_s.rdata = {31'h00000000, s.linear};
                `ADDR_PPR: next_s.rdata = s.ppr;
                `ADDR_LRES: next_s.rdata = s.lres;
                `ADDR_ENC_RES: next_s.rdata = s.enc_res;
                `ADDR_PITCH: next_s.rdata = s.pitch;
                `ADDR_STATUS: begin
                    next_s.rdata = {16'h0000, s.idx_count};
                    next_s.rdata[`STS_ARMED_BIT] = s.armed;
                    next_s.rdata[`STS_INDEX_BIT] = s.pc;
                    next_s.rdata[`STS_BUSY_BIT] = q_busy;
                end
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        // settings go live only on a restart; the restart also clears all motion state
        if (s.restart) begin
            next_s.act_both = s.idx_opt[`OPT_BOTH_BIT];
            next_s.act_linear = s.linear;
            if (s.linear) begin
                next_s.act_num = {1'b0, s.lres};
                next_s.act_den = s.pitch;
            end else begin
                next_s.act_num = {s.ppr[30:0], 2'b00};
                next_s.act_den = s.enc_res;
            end
            next_s.act_off = s.pitch >> `PITCH_OFFSET_SHIFT;
            next_s.armed = 1'b0;
            next_s.istate = IDX_IDLE;
            next_s.delay = 32'h00000000;
            next_s.width = 2'h0;
        end else begin
            case (s.istate)
                IDX_IDLE: begin
                    // an accepted mark starts the index where it is met, except in linear both mode, which first waits act_off encoder counts
                    if (origin_ok) begin
                        if (s.act_linear && i_enc_dir) begin
                            next_s.armed = 1'b1;
                        end
                        if (s.act_linear && s.act_both) begin
                            next_s.istate = IDX_DELAY;
                            next_s.delay = s.act_off;
                        end else begin
                            next_s.istate = IDX_HOLD;
                            next_s.width = `IDX_WIDTH_EDGES;
                        end
                    end
                end
                IDX_DELAY: begin
                    if (s.delay == 32'h00000000) begin
                        next_s.istate = IDX_HOLD;
                        next_s.width = `IDX_NARROW_EDGES;
                    end else if (i_enc_step) begin
                        next_s.delay = s.delay - 32'h00000001;
                    end
                end
                IDX_HOLD: begin
                    if (q_edge) begin
                        next_s.width = s.width - 2'h1;
                        if (s.width == 2'h1) begin
                            next_s.istate = IDX_IDLE;
                            next_s.idx_count = s.idx_count + 16'h0001;
                        end
                    end
                end
                default: begin
                    next_s.istate = IDX_IDLE;
                end
            endcase
        end
        // output form depends only on count direction, never on the motion sense
        next_s.pa = qa;
        next_s.pb = qb;
        next_s.pa_n = !qa;
        next_s.pb_n = !qb;
        next_s.pc = (next_s.istate == IDX_HOLD);
        next_s.pc_n = (next_s.istate != IDX_HOLD);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            s <= '0;
            s.idx_opt <= `INDEX_OPT_RESET;
            s.ppr <= `PPR_RESET;
            s.lres <= `LRES_RESET;
            s.enc_res <= `ENC_RES_RESET;
            s.pitch <= `PITCH_RESET;
            s.act_num <= {1'b0, `PPR_RESET} << 2;
            s.act_den <= `ENC_RES_RESET;
            s.act_off <= `PITCH_RESET >> `PITCH_OFFSET_SHIFT;
            s.pa_n <= 1'b1;
            s.pb_n <= 1'b1;
            s.pc_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_wb_ack = s.ack;
    assign o_wb_dat = s.rdata;
    assign o_phase_a_out = s.pa;
    assign o_phase_a_out_n = s.pa_n;
    assign o_phase_b_out = s.pb;
    assign o_phase_b_out_n = s.pb_n;
    assign o_index_out = s.pc;
    assign o_index_out_n = s.pc_n;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    property p_comp_a;
        o_phase_a_out_n == !o_phase_a_out;
    endproperty
    a_comp_a: assert property (p_comp_a) else $error("phase a complement wrong");

    property p_comp_b;
        o_phase_b_out_n != o_phase_b_out;
    endproperty
    a_comp_b: assert property (p_comp_b) else $error("phase b complement wrong");

    property p_comp_c;
        o_index_out ^ o_index_out_n;
    endproperty
    a_comp_c: assert property (p_comp_c) else $error("index complement wrong");

    property p_quad;
        $changed(o_phase_a_out) |-> $stable(o_phase_b_out);
    endproperty
    a_quad: assert property (p_quad) else $error("a and b changed together");

    property p_gap;
        ($changed(o_phase_a_out) || $changed(o_phase_b_out)) && !$past(s.restart)
            |=> ($stable(o_phase_a_out) && $stable(o_phase_b_out)) [*6];
    endproperty
    a_gap: assert property (p_gap) else $error("output edges too close");

    property p_fwd_only;
        (s.istate == IDX_IDLE && !s.restart && s.act_linear && !s.act_both
            && i_enc_origin && !i_enc_dir) |=> s.istate == IDX_IDLE ##1 !o_index_out;
    endproperty
    a_fwd_only: assert property (p_fwd_only) else $error("reverse index in forward mode");

    property p_rev_blocked;
        (s.istate == IDX_IDLE && !s.restart && s.act_linear && s.act_both && !s.armed
            && i_enc_origin && !i_enc_dir) |=> s.istate == IDX_IDLE;
    endproperty
    a_rev_blocked: assert property (p_rev_blocked) else $error("index before forward pass");

    property p_rev_armed;
        (s.istate == IDX_IDLE && !s.restart && s.act_linear && s.act_both && s.armed
            && i_enc_origin && !i_enc_dir) |=> s.istate == IDX_DELAY;
    endproperty
    a_rev_armed: assert property (p_rev_armed) else $error("reverse index missing");

    property p_rotary_index;
        (s.istate == IDX_IDLE && !s.restart && !s.act_linear && i_enc_origin)
            |=> ##1 o_index_out;
    endproperty
    a_rotary_index: assert property (p_rotary_index) else $error("rotary index missing");

    property p_width;
        (s.istate == IDX_HOLD && !s.restart && q_edge && s.width == 2'h1)
            |=> s.istate == IDX_IDLE ##1 !o_index_out;
    endproperty
    a_width: assert property (p_width) else $error("index width wrong");

    property p_ack;
        (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus not acknowledged");

    c_fwd_index: cover property (s.act_linear && !s.act_both && $rose(o_index_out));
    c_rev_index: cover property (s.act_both && s.istate == IDX_DELAY && !i_enc_dir);
    c_rotary_index: cover property (!s.act_linear && $fell(o_index_out));
    c_restart: cover property (s.restart);
endmodule

// File: rtl/edpo_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef EDPO_REGS_SVH
`define EDPO_REGS_SVH

`define ADDR_INDEX_OPT 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_PPR 8'h08
`define ADDR_LRES 8'h0c
`define ADDR_ENC_RES 8'h10
`define ADDR_PITCH 8'h14
`define ADDR_STATUS 8'h18

`define CFG_LINEAR_BIT 0
`define CFG_RESTART_BIT 1
`define OPT_BOTH_BIT 0
`define STS_ARMED_BIT 16
`define STS_INDEX_BIT 17
`define STS_BUSY_BIT 18

`define INDEX_OPT_RESET 16'h0000
`define PPR_RESET 32'h00000800
`define LRES_RESET 32'h00000014
`define ENC_RES_RESET 32'h00100000
`define PITCH_RESET 32'h00000400

`define CLK_KHZ 40000
`define MAX_OUT_KPPS 1600
`define EDGE_GAP_CYCLES ((`CLK_KHZ + 4 * `MAX_OUT_KPPS - 1) / (4 * `MAX_OUT_KPPS))
`define IDX_WIDTH_EDGES 2'h2
`define IDX_NARROW_EDGES 2'h1
`define PITCH_OFFSET_SHIFT 3

`endif

// File: rtl/edpo_pkg.sv
// types shared by the divided pulse output modules
package edpo_pkg;
    typedef enum logic [1:0] {
        IDX_IDLE = 2'b00,
        IDX_DELAY = 2'b01,
        IDX_HOLD = 2'b10
    } idx_state_t;

    typedef struct packed {
        logic signed [35:0] acc;
        logic up;
        logic down;
    } divider_state_t;

    typedef struct packed {
        logic signed [15:0] pend;
        logic [3:0] gap;
        logic [1:0] q;
        logic a;
        logic b;
        logic edge_seen;
    } stepper_state_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] idx_opt;
        logic linear;
        logic [31:0] ppr;
        logic [31:0] lres;
        logic [31:0] enc_res;
        logic [31:0] pitch;
        logic restart;
        logic act_both;
        logic act_linear;
        logic [32:0] act_num;
        logic [31:0] act_den;
        logic [31:0] act_off;
        logic armed;
        idx_state_t istate;
        logic [31:0] delay;
        logic [1:0] width;
        logic [15:0] idx_count;
        logic pa;
        logic pa_n;
        logic pb;
        logic pb_n;
        logic pc;
        logic pc_n;
    } edpo_state_t;
endpackage

// File: rtl/pulse_divider.sv
// rate divider: turns encoder counts into output edge requests
`timescale 1ns/10ps
module pulse_divider import edpo_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_restart,
    input wire logic i_step,
    input wire logic i_dir,
    input wire logic [32:0] i_num,
    input wire logic [31:0] i_den,
    output logic o_up,
    output logic o_down
);
    divider_state_t s;
    divider_state_t next_s;
    logic signed [35:0] den_s;
    logic signed [35:0] num_s;

    assign den_s = signed'({4'h0, i_den});
    assign num_s = signed'({3'h0, i_num});

    always_comb begin
        logic signed [35:0] a;
        a = s.acc;
        next_s = s;
        next_s.up = 1'b0;
        next_s.down = 1'b0;
        // one edge per cycle at most; any surplus drains in later cycles
        if (i_den != 32'h00000000 && a >= den_s) begin
            a = a - den_s;
            next_s.up = 1'b1;
        end else if (i_den != 32'h00000000 && a <= -den_s) begin
            a = a + den_s;
            next_s.down = 1'b1;
        end
        if (i_step) begin
            a = i_dir ? a + num_s : a - num_s;
        end
        next_s.acc = a;
        if (i_restart) begin
            next_s = '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_up = s.up;
    assign o_down = s.down;
endmodule

// File: rtl/quad_edge_gen.sv
// quadrature edge generator with a minimum spacing between edges
`timescale 1ns/10ps
`include "edpo_regs.svh"
module quad_edge_gen import edpo_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_restart,
    input wire logic i_up,
    input wire logic i_down,
    output logic o_a,
    output logic o_b,
    output logic o_edge,
    output logic o_busy
);
    // reload is one below the spacing: the gap counts down 6 cycles and the next edge may come on the 7th
    localparam logic [3:0] GAP_RELOAD = 4'((`EDGE_GAP_CYCLES) - 1);
    stepper_state_t s;
    stepper_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.edge_seen = 1'b0;
        if (i_up) begin
            next_s.pend = s.pend + 16'sh0001;
        end else if (i_down) begin
            next_s.pend = s.pend - 16'sh0001;
        end
        // backlog is paced out so the pulse rate never exceeds the limit
        if (s.gap != 4'h0) begin
            next_s.gap = s.gap - 4'h1;
        end else if (next_s.pend > 16'sh0000) begin
            next_s.q = s.q + 2'h1;
            next_s.pend = next_s.pend - 16'sh0001;
            next_s.gap = GAP_RELOAD;
            next_s.edge_seen = 1'b1;
        end else if (next_s.pend < 16'sh0000) begin
            next_s.q = s.q - 2'h1;
            next_s.pend = next_s.pend + 16'sh0001;
            next_s.gap = GAP_RELOAD;
            next_s.edge_seen = 1'b1;
        end
        // forward order 00, 10, 11, 01: a leads b by a quarter period
        next_s.a = next_s.q[0] ^ next_s.q[1];
        next_s.b = next_s.q[1];
        if (i_restart) begin
            next_s = '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_a = s.a;
    assign o_b = s.b;
    assign o_edge = s.edge_seen;
    assign o_busy = (s.pend != 16'sh0000);
endmodule

// File: sim/quad_host_model.sv
// host side model: decodes the quadrature feedback and counts index pulses
`timescale 1ns/10ps
module quad_host_model (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_phase_a,
    input wire logic i_phase_a_n,
    input wire logic i_phase_b,
    input wire logic i_phase_b_n,
    input wire logic i_index,
    input wire logic i_index_n,
    output logic signed [31:0] o_position,
    output logic [15:0] o_index_count,
    output logic [7:0] o_index_width,
    output logic [15:0] o_fault_count
);
    logic [1:0] prev_ab;
    logic prev_c;
    logic [7:0] width_run;

    // the host has no homing sequence, it only counts what it sees
    always_ff @(posedge i_core_clk) begin
        logic [3:0] step_code;
        logic [15:0] faults;
        logic ab_moved;
        step_code = {prev_ab, i_phase_a, i_phase_b};
        faults = o_fault_count;
        ab_moved = ({i_phase_a, i_phase_b} !== prev_ab);
        if (!i_resetn) begin
            prev_ab <= 2'h0;
            prev_c <= 1'b0;
            width_run <= 8'h0;
            o_position <= 32'sh0;
            o_index_count <= 16'h0;
            o_index_width <= 8'h0;
            o_fault_count <= 16'h0;
        end else begin
            prev_ab <= {i_phase_a, i_phase_b};
            prev_c <= i_index;
            // a line pair that is not complementary is a wiring fault to the host
            if (i_phase_a_n === i_phase_a || i_phase_b_n === i_phase_b || i_index_n === i_index) begin
                faults = faults + 16'h1;
            end
            if ({i_phase_a, i_phase_b} !== prev_ab) begin
                case (step_code)
                    4'b0010, 4'b1011, 4'b1101, 4'b0100: o_position <= o_position + 32'sh1;
                    4'b0001, 4'b0111, 4'b1110, 4'b1000: o_position <= o_position - 32'sh1;
                    default: faults = faults + 16'h1;
                endcase
            end
            o_fault_count <= faults;
            if (i_index && !prev_c) begin
                o_index_count <= o_index_count + 16'h1;
                width_run <= 8'h0;
            end else if (prev_c && ab_moved) begin
                // width in edge intervals: the edge that ends the pulse counts too
                width_run <= width_run + 8'h1;
            end
            if (!i_index && prev_c) begin
                o_index_width <= width_run + (ab_moved ? 8'h1 : 8'h0);
            end
        end
    end
endmodule

// File: sim/test_encoder_divided_pulse_output.sv
// self-checking bench for the encoder divided pulse output
`timescale 1ns/10ps
`include "edpo_regs.svh"
module test_encoder_divided_pulse_output;
    localparam int ENC_CNT = 16;
    localparam int PPR = 4;
    localparam int PITCH = 16;
    localparam int LRES = 8;
    logic core_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_rdat, rd;
    logic enc_step, enc_dir, enc_origin;
    logic pa, pa_n, pb, pb_n, pc, pc_n;
    logic signed [31:0] host_pos;
    logic [15:0] host_idx, host_faults;
    logic [7:0] host_width;
    logic [1:0] prev_ab;
    int err_total, comparisons, gap_cnt, exp_pos;
    logic [7:0] map_adr [7] = '{`ADDR_INDEX_OPT, `ADDR_CONFIG, `ADDR_PPR, `ADDR_LRES,
        `ADDR_ENC_RES, `ADDR_PITCH, 8'h1c};
    logic [31:0] map_rst [7] = '{32'(`INDEX_OPT_RESET), 32'h0, `PPR_RESET, `LRES_RESET,
        `ENC_RES_RESET, `PITCH_RESET, 32'h0};

    encoder_divided_pulse_output uut (.i_core_clk(core_clk), .i_resetn(resetn),
        .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
        .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
        .i_enc_step(enc_step), .i_enc_dir(enc_dir), .i_enc_origin(enc_origin),
        .o_phase_a_out(pa), .o_phase_a_out_n(pa_n), .o_phase_b_out(pb),
        .o_phase_b_out_n(pb_n), .o_index_out(pc), .o_index_out_n(pc_n));
    quad_host_model host (.i_core_clk(core_clk), .i_resetn(resetn), .i_phase_a(pa),
        .i_phase_a_n(pa_n), .i_phase_b(pb), .i_phase_b_n(pb_n), .i_index(pc),
        .i_index_n(pc_n), .o_position(host_pos), .o_index_count(host_idx),
        .o_index_width(host_width), .o_fault_count(host_faults));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic tally_and_finish;
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            check({31'h0, wb_ack}, 32'h1);
            tally_and_finish;
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask

    task automatic steps(input int n, input logic d, input int space);
        for (int i = 0; i < n; i++) begin
            enc_step <= 1'b1;
            enc_dir <= d;
            @(posedge core_clk);
            if (space > 1 || i == n - 1) begin
                enc_step <= 1'b0;
                repeat (space - 1) @(posedge core_clk);
            end
        end
    endtask

    // waits until the edge backlog has gone out on the pins
    task automatic drain;
        int n;
        n = 0;
        repeat (4) @(posedge core_clk);
        do begin
            wb_cycle(1'b0, `ADDR_STATUS, 32'h0);
            n++;
        end while (rd[`STS_BUSY_BIT] !== 1'b0 && n < 100);
        if (rd[`STS_BUSY_BIT] !== 1'b0) begin
            check({31'h0, rd[`STS_BUSY_BIT]}, 32'h0);
            tally_and_finish;
        end
        repeat (4) @(posedge core_clk);
    endtask

    task automatic origin_chk(input logic d, input logic exp);
        enc_origin <= 1'b1;
        enc_dir <= d;
        @(posedge core_clk);
        enc_origin <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({31'h0, pc}, {31'h0, exp});
    endtask

    // spacing between any two phase changes on the pins
    always @(posedge core_clk) begin
        if (!resetn) begin
            gap_cnt <= 100;
        end else if ({pa, pb} !== prev_ab) begin
            check(gap_cnt >= `EDGE_GAP_CYCLES, 32'h1);
            gap_cnt <= 1;
        end else if (gap_cnt < 100) begin
            gap_cnt <= gap_cnt + 1;
        end
        prev_ab <= {pa, pb};
    end

    initial begin
        resetn = 1'b0;
        {wb_cyc, wb_stb, wb_we, enc_step, enc_dir, enc_origin} = 6'h0;
        wb_adr = 8'h0;
        wb_sel = 4'hf;
        wb_dat = 32'h0;
        err_total = 0;
        comparisons = 0;
        exp_pos = 0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        check({26'h0, pa, pa_n, pb, pb_n, pc, pc_n}, 32'h15);
        for (int i = 0; i < 7; i++) begin
            rd_chk(map_adr[i], map_rst[i]);
        end
        rd_chk(`ADDR_STATUS, 32'h0);
        wb_cycle(1'b1, 8'h1c, 32'hffffffff);
        rd_chk(8'h1c, 32'h0);
        wb_cycle(1'b1, `ADDR_STATUS, 32'hffffffff);
        rd_chk(`ADDR_STATUS, 32'h0);
        // rotary: one output edge per encoder count
        wb_cycle(1'b1, `ADDR_ENC_RES, ENC_CNT);
        wb_cycle(1'b1, `ADDR_PPR, PPR);
        wb_cycle(1'b1, `ADDR_CONFIG, 32'h2);
        rd_chk(`ADDR_CONFIG, 32'h0);
        steps(ENC_CNT, 1'b1, 8);
        exp_pos += 4 * PPR;
        drain;
        check(host_pos, exp_pos);
        steps(ENC_CNT, 1'b0, 1);
        exp_pos -= 4 * PPR;
        drain;
        check(host_pos, exp_pos);
        // two turns made above before the index is used
        origin_chk(1'b1, 1'b1);
        steps(4, 1'b1, 8);
        drain;
        check(host_idx, 32'h1);
        check(host_width, 32'h2);
        origin_chk(1'b0, 1'b1);
        steps(4, 1'b0, 8);
        drain;
        wb_cycle(1'b0, `ADDR_STATUS, 32'h0);
        check({16'h0, rd[15:0]}, 32'h2);
        // linear, forward-only index
        wb_cycle(1'b1, `ADDR_LRES, LRES);
        wb_cycle(1'b1, `ADDR_PITCH, PITCH);
        wb_cycle(1'b1, `ADDR_CONFIG, 32'h3);
        origin_chk(1'b0, 1'b0);
        steps(PITCH, 1'b1, 8);
        exp_pos += LRES;
        drain;
        origin_chk(1'b1, 1'b1);
        steps(PITCH, 1'b1, 8);
        exp_pos += LRES;
        drain;
        check(host_idx, 32'h3);
        check(host_width, 32'h2);
        origin_chk(1'b0, 1'b0);
        steps(PITCH, 1'b0, 8);
        exp_pos -= LRES;
        drain;
        check(host_pos, exp_pos);
        wb_cycle(1'b1, `ADDR_INDEX_OPT, 32'h1);
        origin_chk(1'b0, 1'b0);
        // linear, both directions after restart
        wb_cycle(1'b1, `ADDR_CONFIG, 32'h3);
        origin_chk(1'b0, 1'b0);
        steps(PITCH, 1'b0, 8);
        exp_pos -= LRES;
        drain;
        check(host_idx, 32'h3);
        origin_chk(1'b1, 1'b0);
        steps(PITCH, 1'b1, 8);
        exp_pos += LRES;
        drain;
        check(host_idx, 32'h4);
        check(host_width, 32'h1);
        origin_chk(1'b0, 1'b0);
        steps(PITCH, 1'b0, 8);
        exp_pos -= LRES;
        drain;
        check(host_idx, 32'h5);
        check(host_pos, exp_pos);
        check(host_faults, 32'h0);
        tally_and_finish;
    end
endmodule
